// File: hw/timer_ctrl_consts.vh
`ifndef TIMER_CTRL_CONSTS_VH
`define TIMER_CTRL_CONSTS_VH

// Register offsets
`define OFS_SPLIT_SELECT   4'h3
`define OFS_CTRL_E_CLEAR   4'h4
`define OFS_CTRL_E_SET     4'h5
`define OFS_BV_CLEAR       4'h6
`define OFS_BV_SET         4'h7
`define OFS_HW_CONTROL     4'h8

// Split select field
`define SPLIT_BIT          0

// Control E fields
`define CE_DIR_BIT         0
`define CE_LOCK_UPDATE_BIT        1
`define CE_CMD_LSB         2
`define CE_CMD_MSB         3

// Command encodings
`define CMD_NONE           2'h0
`define CMD_UPDATE         2'h1
`define CMD_RESTART        2'h2
`define CMD_HARD_RESET     2'h3

// Buffer valid fields
`define BV_PER_BIT         0
`define BV_CMP_LSB         1
`define BV_CMP_MSB         3

// Hardware control fields (enable, auto lock, compare enables)
`define HC_ENABLE_BIT      0
`define HC_AUTO_LOCK_UPDATE_BIT       1
`define HC_CMPEN_LSB       2
`define HC_CMPEN_MSB       4

// Waveform modes
`define WG_DSTOP           3'h5
`define WG_DSBOTH          3'h6
`define WG_DSBOTTOM        3'h7

`define RESET_BYTE         8'h00
`define ZERO_BYTE          8'h00

`endif

// File: hw/command_decoder.v
`timescale 1ns/100ps
`include "timer_ctrl_consts.vh"

module command_decoder (
  input  wire       cmd_write,
  input  wire [1:0] cmd_value,
  input  wire       timer_enabled,
  output wire       force_update,
  output wire       force_restart,
  output wire       force_hard_reset
);

  assign force_update     = cmd_write && (cmd_value == `CMD_UPDATE);
  assign force_restart    = cmd_write && (cmd_value == `CMD_RESTART);
  // Hard reset while running would corrupt a live waveform
  assign force_hard_reset = cmd_write && (cmd_value == `CMD_HARD_RESET)
                            && !timer_enabled;

endmodule // command_decoder

// File: hw/direction_tracker.v
`timescale 1ns/100ps
`include "timer_ctrl_consts.vh"

module direction_tracker (
  input  wire [2:0] wave_mode,
  input  wire       at_top,
  input  wire       at_bottom,
  input  wire       event_updown_en,
  input  wire       event_level,
  output reg        hw_dir_load,
  output reg        hw_dir_value
);

  always @* begin
    hw_dir_load  = 1'b0;
    hw_dir_value = 1'b0;
    // Event action overrides the mode turnaround
    if (event_updown_en) begin
      hw_dir_load  = 1'b1;
      hw_dir_value = event_level;
    end else if (wave_mode == `WG_DSTOP || wave_mode == `WG_DSBOTH ||
                 wave_mode == `WG_DSBOTTOM) begin
      if (at_top) begin
        hw_dir_load  = 1'b1;
        hw_dir_value = 1'b1;
      end else if (at_bottom) begin
        hw_dir_load  = 1'b1;
        hw_dir_value = 1'b0;
      end
    end
  end

endmodule // direction_tracker

// File: hw/timer_update_control_regs.v
`timescale 1ns/100ps
`include "timer_ctrl_consts.vh"

// Behaviour
// - Split bit one makes two 8-bit timers and changes register map; here it only drives split_mode_enable, register map unchanged.
// - Writing one to a clear register bit clears that control bit.
// - Writing one to a set register bit sets that control bit.
// - Command 0 none, 1 update, 2 restart, 3 hard reset.
// - Command bits always read zero in set and clear registers.
// - Hard reset command ignored while timer enabled.
// - Lock update one blocks buffer transfer; zero transfers on update.
// - Direction zero counts up, one down; software set/clear changes it.
// - Hardware changes direction at dual-slope turnarounds and on event actions.
// - Compare buffer write sets that channel's buffer valid flag.
// - Period buffer write sets the period buffer valid flag.
// - Update condition clears all buffer valid flags.
// - Auto lock holds lock update until all enabled compare flags valid.
// - Next update after auto clear transfers buffers, then relocks.
module timer_update_control_regs (
  input  wire       mclk,
  input  wire       rstn,
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  input  wire       update_condition,
  input  wire       period_buffer_write,
  input  wire [2:0] compare_buffer_write,
  input  wire [2:0] wave_mode,
  input  wire       at_top,
  input  wire       at_bottom,
  input  wire       event_updown_en,
  input  wire       event_level,
  output reg        split_mode_enable,
  output reg        lock_update,
  output reg        count_down,
  output reg        period_buffer_valid,
  output reg  [2:0] compare_buffer_valid,
  output reg        buffer_transfer,
  output reg        update_pulse,
  output reg        restart_pulse,
  output reg        hard_reset_pulse,
  output reg        timer_enabled
);

  reg        auto_lock_update_reg;
  reg  [2:0] compare_enable_reg;
  reg        lock_next;
  reg        dir_next;
  reg  [3:0] bv_next;
  reg  [7:0] rdata_next;
  wire       wr_e_clr;
  wire       wr_e_set;
  wire       wr_bv_clr;
  wire       wr_bv_set;
  wire       cmd_write;
  wire [1:0] cmd_value;
  wire       force_update;
  wire       force_restart;
  wire       force_hard_reset;
  wire       hw_dir_load;
  wire       hw_dir_value;
  wire       upd_event;
  wire       all_enabled_valid;

  assign wr_e_clr  = wr_stb && (addr == `OFS_CTRL_E_CLEAR);
  assign wr_e_set  = wr_stb && (addr == `OFS_CTRL_E_SET);
  assign wr_bv_clr = wr_stb && (addr == `OFS_BV_CLEAR);
  assign wr_bv_set = wr_stb && (addr == `OFS_BV_SET);
  assign cmd_write = wr_e_clr || wr_e_set;
  assign cmd_value = wdata[`CE_CMD_MSB:`CE_CMD_LSB];

  command_decoder u_cmd (
    .cmd_write        (cmd_write),
    .cmd_value        (cmd_value),
    .timer_enabled    (timer_enabled),
    .force_update     (force_update),
    .force_restart    (force_restart),
    .force_hard_reset (force_hard_reset)
  );

  direction_tracker u_dir (
    .wave_mode       (wave_mode),
    .at_top          (at_top),
    .at_bottom       (at_bottom),
    .event_updown_en (event_updown_en),
    .event_level     (event_level),
    .hw_dir_load     (hw_dir_load),
    .hw_dir_value    (hw_dir_value)
  );

  // A forced update counts as an update condition
  assign upd_event = update_condition || force_update;

  // Disabled channels do not hold the lock
  assign all_enabled_valid =
    ((compare_buffer_valid | ~compare_enable_reg) == 3'h7);

  always @* begin
    lock_next = lock_update;
    if (wr_e_clr && wdata[`CE_LOCK_UPDATE_BIT])
      lock_next = 1'b0;
    if (wr_e_set && wdata[`CE_LOCK_UPDATE_BIT])
      lock_next = 1'b1;
    if (auto_lock_update_reg) begin
      if (upd_event && !lock_update)
        lock_next = 1'b1;
      else if (all_enabled_valid)
        lock_next = 1'b0;
      else
        lock_next = 1'b1;
    end
  end

  always @* begin
    dir_next = count_down;
    if (hw_dir_load)
      dir_next = hw_dir_value;
    if (wr_e_clr && wdata[`CE_DIR_BIT])
      dir_next = 1'b0;
    if (wr_e_set && wdata[`CE_DIR_BIT])
      dir_next = 1'b1;
  end

  always @* begin
    bv_next = {compare_buffer_valid, period_buffer_valid};
    if (upd_event)
      bv_next = 4'h0;
    if (wr_bv_clr)
      bv_next = bv_next & ~wdata[`BV_CMP_MSB:`BV_PER_BIT];
    if (wr_bv_set)
      bv_next = bv_next | wdata[`BV_CMP_MSB:`BV_PER_BIT];
    // New buffer writes win over a same-cycle clear
    if (period_buffer_write)
      bv_next[`BV_PER_BIT] = 1'b1;
    bv_next[`BV_CMP_MSB:`BV_CMP_LSB] =
      bv_next[`BV_CMP_MSB:`BV_CMP_LSB] | compare_buffer_write;
  end

  always @* begin
    rdata_next = `ZERO_BYTE;
    case (addr)
      `OFS_SPLIT_SELECT: rdata_next = {7'h00, split_mode_enable};
      // Command field always reads as zero
      `OFS_CTRL_E_CLEAR,
      `OFS_CTRL_E_SET:   rdata_next = {6'h00, lock_update, count_down};
      `OFS_BV_CLEAR,
      `OFS_BV_SET:       rdata_next = {4'h0, compare_buffer_valid,
                                       period_buffer_valid};
      `OFS_HW_CONTROL:   rdata_next = {3'h0, compare_enable_reg,
                                       auto_lock_update_reg, timer_enabled};
      default:           rdata_next = `ZERO_BYTE;
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata                <= `RESET_BYTE;
      split_mode_enable    <= 1'b0;
      lock_update          <= 1'b0;
      count_down           <= 1'b0;
      period_buffer_valid  <= 1'b0;
      compare_buffer_valid <= 3'h0;
      buffer_transfer      <= 1'b0;
      update_pulse         <= 1'b0;
      restart_pulse        <= 1'b0;
      hard_reset_pulse     <= 1'b0;
      timer_enabled        <= 1'b0;
      auto_lock_update_reg <= 1'b0;
      compare_enable_reg   <= 3'h0;
    end else if (force_hard_reset) begin
      // Hard reset returns the timer state to reset values
      rdata                <= `RESET_BYTE;
      split_mode_enable    <= 1'b0;
      lock_update          <= 1'b0;
      count_down           <= 1'b0;
      period_buffer_valid  <= 1'b0;
      compare_buffer_valid <= 3'h0;
      buffer_transfer      <= 1'b0;
      update_pulse         <= 1'b0;
      restart_pulse        <= 1'b0;
      hard_reset_pulse     <= 1'b1;
      auto_lock_update_reg <= 1'b0;
      compare_enable_reg   <= 3'h0;
    end else begin
      rdata               <= rd_stb ? rdata_next : `ZERO_BYTE;
      if (wr_stb && addr == `OFS_SPLIT_SELECT)
        split_mode_enable <= wdata[`SPLIT_BIT];
      if (wr_stb && addr == `OFS_HW_CONTROL) begin
        timer_enabled        <= wdata[`HC_ENABLE_BIT];
        auto_lock_update_reg <= wdata[`HC_AUTO_LOCK_UPDATE_BIT];
        compare_enable_reg   <= wdata[`HC_CMPEN_MSB:`HC_CMPEN_LSB];
      end
      lock_update          <= lock_next;
      count_down           <= dir_next;
      period_buffer_valid  <= bv_next[`BV_PER_BIT];
      compare_buffer_valid <= bv_next[`BV_CMP_MSB:`BV_CMP_LSB];
      buffer_transfer      <= upd_event && !lock_update;
      update_pulse         <= force_update;
      restart_pulse        <= force_restart;
      hard_reset_pulse     <= 1'b0;
    end
  end

endmodule // timer_update_control_regs

// File: testbench/ctrl_regs_properties.sv
`timescale 1ns/100ps
module ctrl_regs_checker (
  input wire       mclk,
  input wire       rstn,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire       wr_stb,
  input wire       rd_stb,
  input wire [7:0] rdata,
  input wire       period_buffer_write,
  input wire [2:0] compare_buffer_write,
  input wire       split_mode_enable,
  input wire       lock_update,
  input wire       count_down,
  input wire       period_buffer_valid,
  input wire [2:0] compare_buffer_valid,
  input wire       buffer_transfer,
  input wire       update_pulse,
  input wire       restart_pulse,
  input wire       hard_reset_pulse,
  input wire       timer_enabled
);
  wire e_wr = wr_stb && (addr == 4'h4 || addr == 4'h5);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_cmd_update: assert property (e_wr && wdata[3:2] == 2'h1 |=> update_pulse && !restart_pulse)
    else $error("cmd update");
  a_cmd_restart: assert property (e_wr && wdata[3:2] == 2'h2 |=> restart_pulse && !update_pulse)
    else $error("cmd restart");
  a_hard_gate: assert property (e_wr && wdata[3:2] == 2'h3 |=> hard_reset_pulse == !$past(timer_enabled))
    else $error("hard reset gate");
  a_cmd_zero: assert property (rd_stb && (addr == 4'h4 || addr == 4'h5) |=> rdata[3:2] == 2'h0)
    else $error("cmd read");
  // Read data must not linger, or software sees stale bits
  a_rdata_idle: assert property (!rd_stb || addr < 4'h3 || addr > 4'h8 |=> rdata == 8'h00)
    else $error("rdata idle");
  a_per_valid: assert property (period_buffer_write && !wr_stb |=> period_buffer_valid)
    else $error("period valid");
  a_cmp_valid: assert property (compare_buffer_write != 3'h0 && !wr_stb |=>
    (compare_buffer_valid & $past(compare_buffer_write)) == $past(compare_buffer_write))
    else $error("compare valid");
  a_lock_blocks: assert property (buffer_transfer |-> !$past(lock_update))
    else $error("lock blocks");
  a_dir_set: assert property (wr_stb && addr == 4'h5 && wdata[0] && wdata[3:2] != 2'h3 |=> count_down)
    else $error("dir set");
  a_split_wr: assert property (wr_stb && addr == 4'h3 |=> split_mode_enable == $past(wdata[0]))
    else $error("split");
endmodule // ctrl_regs_checker
bind timer_update_control_regs ctrl_regs_checker chk_i (.*);

// File: testbench/testbench.sv
`timescale 1ns/100ps
`include "timer_ctrl_consts.vh"
module testbench;
  reg         mclk, rstn, wr_stb, rd_stb, upd, pbw, top, bot, ev_en, ev_lvl;
  reg  [3:0]  addr;
  reg  [7:0]  wdata, st, d;
  reg  [2:0]  cbw, wmode;
  reg  [31:0] lfsr_reg;
  wire [7:0]  rdata;
  wire [2:0]  cbv;
  wire        split, lock, down, pbv, xfer, updp, rstp, hrp, ten;
  integer     bad_count, compares, cycles, c, i;
  timer_update_control_regs dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .update_condition(upd),
    .period_buffer_write(pbw), .compare_buffer_write(cbw), .wave_mode(wmode), .at_top(top),
    .at_bottom(bot), .event_updown_en(ev_en), .event_level(ev_lvl), .split_mode_enable(split),
    .lock_update(lock), .count_down(down), .period_buffer_valid(pbv),
    .compare_buffer_valid(cbv), .buffer_transfer(xfer), .update_pulse(updp),
    .restart_pulse(rstp), .hard_reset_pulse(hrp), .timer_enabled(ten));
  function [7:0] rnd;
    lfsr_reg = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    rnd = lfsr_reg[7:0];
  endfunction
  // Pulse pattern {hard reset, restart, update} expected from a command code
  function [7:0] cmd_exp(input integer k);
    cmd_exp = (k == 0) ? 8'h00 : 8'h01 << (k - 1);
  endfunction
  task chk(input string n, input [7:0] s, input [7:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input [3:0] a, input [7:0] v);
    @(posedge mclk);
    addr <= a; wdata <= v; wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge mclk);
    addr <= a; rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task pin(input u, input p, input [2:0] cw, input t, input b);
    @(posedge mclk);
    upd <= u; pbw <= p; cbw <= cw; top <= t; bot <= b;
    @(posedge mclk);
    upd <= 1'b0; pbw <= 1'b0; cbw <= 3'h0; top <= 1'b0; bot <= 1'b0;
    #1;
  endtask
  task end_of_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 5000) begin
      bad_count++;
      end_of_test;
    end
  end
  initial begin
    {rstn, wr_stb, rd_stb, upd, pbw, top, bot, ev_en, ev_lvl} = 9'h000;
    {addr, wdata, cbw, wmode} = 18'h00000;
    lfsr_reg = 32'h000125CD;
    bad_count = 0; compares = 0; cycles = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    for (i = 2; i < 16; i++) rd(i[3:0], 8'h00);
    d = rnd();
    wr(`OFS_SPLIT_SELECT, d);
    chk("split", 8'(split), 8'(d[0]));
    rd(`OFS_SPLIT_SELECT, 8'(d[0]));
    st = 8'h00;
    for (i = 0; i < 8; i++) begin
      d = rnd() & 8'h03;
      st = st | d;
      wr(`OFS_CTRL_E_SET, d);
      d = rnd() & 8'h03;
      st = st & ~d;
      wr(`OFS_CTRL_E_CLEAR, d);
      rd(`OFS_CTRL_E_SET, st);
      rd(`OFS_CTRL_E_CLEAR, st);
      chk("dir", 8'(down), 8'(st[0]));
    end
    for (c = 0; c < 4; c++)
      for (i = 4; i < 6; i++) begin
        wr(i[3:0], 8'(c << 2));
        chk("cmd", {5'h00, hrp, rstp, updp}, cmd_exp(c));
        rd(i[3:0], 8'h00);
      end
    // An enabled timer must not be torn down by a stray hard reset
    wr(`OFS_HW_CONTROL, 8'h01);
    wr(`OFS_CTRL_E_SET, 8'h0C);
    chk("hard", {6'h00, ten, hrp}, 8'h02);
    wr(`OFS_HW_CONTROL, 8'h00);
    d = rnd();
    pin(1'b0, 1'b1, d[2:0], 1'b0, 1'b0);
    chk("bv", {4'h0, cbv, pbv}, {4'h0, d[2:0], 1'b1});
    wr(`OFS_BV_CLEAR, 8'h01);
    rd(`OFS_BV_SET, {4'h0, d[2:0], 1'b0});
    wr(`OFS_BV_SET, 8'h0F);
    rd(`OFS_BV_CLEAR, 8'h0F);
    pin(1'b1, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("xfer", {4'h0, cbv, xfer}, 8'h01);
    wr(`OFS_CTRL_E_SET, 8'h02);
    pin(1'b1, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("locked", 8'(xfer), 8'h00);
    wr(`OFS_HW_CONTROL, 8'h1E);
    @(posedge mclk);
    #1 chk("alock", 8'(lock), 8'h01);
    pin(1'b0, 1'b0, 3'h7, 1'b0, 1'b0);
    @(posedge mclk);
    #1 chk("aunlock", 8'(lock), 8'h00);
    pin(1'b1, 1'b0, 3'h0, 1'b0, 1'b0);
    chk("axfer", 8'(xfer), 8'h01);
    @(posedge mclk);
    #1 chk("relock", 8'(lock), 8'h01);
    wr(`OFS_HW_CONTROL, 8'h00);
    @(posedge mclk);
    wmode <= `WG_DSBOTH;
    pin(1'b0, 1'b0, 3'h0, 1'b1, 1'b0);
    @(posedge mclk);
    #1 chk("turn top", 8'(down), 8'h01);
    pin(1'b0, 1'b0, 3'h0, 1'b0, 1'b1);
    @(posedge mclk);
    #1 chk("turn bottom", 8'(down), 8'h00);
    @(posedge mclk);
    ev_en <= 1'b1;
    ev_lvl <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("event", 8'(down), 8'h01);
    end_of_test;
  end
endmodule // testbench
